// ==== hdl/link_ctrl_cfg.sv ====
`timescale 1ns/1ps
// Summary of operation
// - set port fault when errors reach limit
// - upper limit byte bits 15:8, reset 01
// - lower limit byte bits 7:0, reset 00
// - abort channel transaction after timeout
// - timeout count bits 7:1, 2 ms steps
// - bit 0 set stops the timeout
// - block bit rejects remote register writes
// - remote access to local targets unaffected
// - sda hold field, 40 ns steps
// - glitch filter width, 5 ns steps
// - ack setup 80 ns plus 640 ns steps
// - sda delay 240 ns plus 40 ns steps
// - watchdog fast 50 us, else 1 s
// - watchdog off bit zero enables detection
// - sda high and quiet means bus free
// - sda stuck low gets nine scl pulses
module link_ctrl_cfg
  import cfg_regs_pkg::*;
#(
  parameter int NUM_PORTS = 2,            // receive ports
  parameter int STEP_CYC  = TMO_STEP_CYC, // cycles per 2 ms
  parameter int SLOW_CYC  = WD_SLOW_CYC   // cycles per 1 s
) (
  input  wire logic                 CLOCK_I,         // system clock
  input  wire logic                 RST_I,           // sync reset, high
  input  wire logic [7:0]           REG_ADDR_I,      // register offset
  input  wire logic [7:0]           REG_WDATA_I,     // write data
  input  wire logic                 REG_WR_I,        // write strobe
  input  wire logic                 REG_RD_I,        // read strobe
  input  wire logic                 REG_REMOTE_I,    // access from control channel
  output logic [7:0]                REG_RDATA_O,     // read data
  output logic                      REG_RVALID_O,    // read data valid
  output logic                      REG_WREJ_O,      // remote write refused
  input  wire logic [NUM_PORTS-1:0] PAR_ERR_I,       // parity error seen
  input  wire logic [NUM_PORTS-1:0] PAR_CLR_I,       // clear count and flag
  output logic [NUM_PORTS-1:0]      PARITY_FAULT_O,  // limit reached
  input  wire logic                 CC_BUSY_I,       // channel transaction open
  output logic                      CC_ABORT_O,      // abort pulse
  input  wire logic                 SCL_I,           // local scl level
  input  wire logic                 SDA_I,           // local sda level
  output logic                      SCL_FILT_O,      // deglitched scl
  output logic                      SDA_FILT_O,      // deglitched sda
  output logic [3:0]                SDA_HOLD_CYC_O,  // sda hold cycles
  output logic [8:0]                ACK_SETUP_CYC_O, // ack setup cycles
  output logic [4:0]                SDA_DELAY_CYC_O, // sda launch cycles
  output logic                      SCL_O,           // scl drive level
  output logic                      SCL_OE_O,        // scl drive enable
  output logic                      BUS_FREE_O,      // bus free
  output logic                      BUS_RECOVER_O    // recovery active
);
  logic [7:0]  upper_q;   // limit high byte
  logic [7:0]  lower_q;   // limit low byte
  logic [7:0]  tmo_q;     // timeout control
  logic [7:0]  first_q;   // i2c port control, first
  logic [7:0]  second_q;  // i2c port control, second
  logic [16:0] pre_q;     // 2 ms prescaler
  logic [6:0]  step_q;    // elapsed 2 ms steps
  logic [1:0]  line_q;    // filtered scl, sda

  // field views
  wire [15:0] parity_error_limit = {upper_q, lower_q};
  wire [6:0]  ctrl_link_timeout_count = tmo_q[7:TMO_CNT_LSB];
  wire        ctrl_link_timeout_off = tmo_q[TMO_OFF_BIT];
  wire        wr_block = first_q[WR_BLOCK_BIT];
  wire [2:0]  hold_f = first_q[HOLD_LSB +: 3];
  wire [3:0]  filt_f = first_q[FILT_LSB +: 4];
  wire [3:0]  setup_f = second_q[SETUP_LSB +: 4];
  wire [1:0]  delay_f = second_q[DELAY_LSB +: 2];
  wire        bus_watchdog_fast = second_q[WD_FAST_BIT];
  wire        wd_off = second_q[WD_OFF_BIT];

  // write decode; a remote write is dropped only when blocked
  wire refuse = REG_WR_I && REG_REMOTE_I && wr_block;
  wire wr_ok  = REG_WR_I && !refuse;
  wire wr_up  = wr_ok && (REG_ADDR_I == OFS_PAR_UPPER);
  wire wr_lo  = wr_ok && (REG_ADDR_I == OFS_PAR_LOWER);
  wire wr_tmo = wr_ok && (REG_ADDR_I == OFS_TMO_CTRL);
  wire wr_1st = wr_ok && (REG_ADDR_I == OFS_I2C_FIRST);
  wire wr_2nd = wr_ok && (REG_ADDR_I == OFS_I2C_SECOND);

  // read select, unmapped offsets read as zero
  logic [7:0] rd_sel;
  always_comb begin
    if (REG_ADDR_I == OFS_PAR_UPPER) begin
      rd_sel = upper_q;
    end else if (REG_ADDR_I == OFS_PAR_LOWER) begin
      rd_sel = lower_q;
    end else if (REG_ADDR_I == OFS_TMO_CTRL) begin
      rd_sel = tmo_q;
    end else if (REG_ADDR_I == OFS_I2C_FIRST) begin
      rd_sel = first_q;
    end else if (REG_ADDR_I == OFS_I2C_SECOND) begin
      rd_sel = second_q;
    end else begin
      rd_sel = 8'h00;
    end
  end

  // register file; this path only guards register writes, so remote
  // traffic to local-bus targets never passes through the block bit
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      upper_q  <= RST_PAR_UPPER;
      lower_q  <= RST_PAR_LOWER;
      tmo_q    <= RST_TMO_CTRL;
      first_q  <= RST_I2C_FIRST;
      second_q <= RST_I2C_SECOND;
    end else begin
      if (wr_up)  upper_q  <= REG_WDATA_I;
      if (wr_lo)  lower_q  <= REG_WDATA_I;
      if (wr_tmo) tmo_q    <= REG_WDATA_I;
      if (wr_1st) first_q  <= REG_WDATA_I;
      if (wr_2nd) second_q <= REG_WDATA_I;
    end
  end

  // read answer and refusal pulse, one cycle after the strobe
  always_ff @(posedge CLOCK_I) begin
    REG_RDATA_O  <= RST_I ? 8'h00 : (REG_RD_I ? rd_sel : REG_RDATA_O);
    REG_RVALID_O <= RST_I ? 1'b0 : REG_RD_I;
    REG_WREJ_O   <= RST_I ? 1'b0 : refuse;
  end

  // per-port parity counters and fault flags
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      logic [15:0] cnt_q; // errors counted, saturating
      wire  [15:0] cnt_nxt = (cnt_q == 16'hffff) ? cnt_q : cnt_q + 16'd1;
      // compare at each new error; set wins over a same-cycle clear
      wire hit = PAR_ERR_I[p] && (cnt_nxt >= parity_error_limit);
      always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
          cnt_q             <= 16'h0000;
          PARITY_FAULT_O[p] <= 1'b0;
        end else begin
          cnt_q             <= PAR_ERR_I[p] ? cnt_nxt : (PAR_CLR_I[p] ? 16'h0000 : cnt_q);
          PARITY_FAULT_O[p] <= hit | (PARITY_FAULT_O[p] & ~PAR_CLR_I[p]);
        end
      end
    end
  endgenerate

  // control channel timeout; a zero count aborts on the first step,
  // which is why software keeps it non-zero
  wire step_tick = (pre_q == 17'(STEP_CYC - 1));
  wire run = CC_BUSY_I && !ctrl_link_timeout_off;
  wire due = run && step_tick && ((step_q + 7'd1) >= ctrl_link_timeout_count);
  always_ff @(posedge CLOCK_I) begin
    if (RST_I || !run) begin
      pre_q  <= '0;
      step_q <= '0;
    end else begin
      pre_q  <= step_tick ? '0 : pre_q + 17'd1;
      step_q <= due ? '0 : (step_tick ? step_q + 7'd1 : step_q);
    end
  end
  always_ff @(posedge CLOCK_I) begin
    CC_ABORT_O <= RST_I ? 1'b0 : due;
  end

  // glitch filter: a level is taken after it stays width+1 samples
  wire [3:0] filt_cyc = 4'((32'(filt_f) * FILT_STEP_NS + CLK_NS - 1) / CLK_NS);
  wire [1:0] raw = {SCL_I, SDA_I};
  genvar b;
  generate
    for (b = 0; b < 2; b++) begin : g_filt
      logic [3:0] run_q; // samples differing from the held level
      always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
          run_q     <= 4'h0;
          line_q[b] <= 1'b1;
        end else if (raw[b] == line_q[b]) begin
          run_q <= 4'h0;
        end else if (run_q >= filt_cyc) begin
          run_q     <= 4'h0;
          line_q[b] <= raw[b];
        end else begin
          run_q <= run_q + 4'h1;
        end
      end
    end
  endgenerate

  // timing settings in cycles, handed to the bus engines
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      SDA_HOLD_CYC_O  <= 4'h0;
      ACK_SETUP_CYC_O <= 9'h000;
      SDA_DELAY_CYC_O <= 5'h00;
      SCL_FILT_O      <= 1'b1;
      SDA_FILT_O      <= 1'b1;
      SCL_O           <= 1'b0;
    end else begin
      SDA_HOLD_CYC_O  <= 4'(32'(hold_f) * HOLD_STEP_CYC);
      ACK_SETUP_CYC_O <= 9'(SETUP_BASE_CYC + 32'(setup_f) * SETUP_STEP_CYC);
      SDA_DELAY_CYC_O <= 5'(DELAY_BASE_CYC + 32'(delay_f) * DELAY_STEP_CYC);
      SCL_FILT_O      <= line_q[1];
      SDA_FILT_O      <= line_q[0];
      SCL_O           <= 1'b0; // open drain, only the enable moves
    end
  end

  // bus watchdog on the filtered lines
  bus_watchdog #(
    .SLOW_CYC (SLOW_CYC),
    .FAST_CYC (WD_FAST_CYC),
    .HALF_CYC (RECOV_HALF_CYC)
  ) u_wd (
    .clk_i    (CLOCK_I),
    .rst_i    (RST_I),
    .en_i     (!wd_off),
    .fast_i   (bus_watchdog_fast),
    .scl_i    (line_q[1]),
    .sda_i    (line_q[0]),
    .free_o   (BUS_FREE_O),
    .recov_o  (BUS_RECOVER_O),
    .scl_oe_o (SCL_OE_O)
  );

  a_fault_set: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    PAR_ERR_I[0] && (g_port[0].cnt_nxt >= parity_error_limit) |=> PARITY_FAULT_O[0])
    else $error("parity fault not raised");
  a_upper_rst: assert property (@(posedge CLOCK_I)
    $past(RST_I) && !RST_I |-> upper_q == 8'h01)
    else $error("upper limit reset wrong");
  a_lower_rst: assert property (@(posedge CLOCK_I)
    $past(RST_I) && !RST_I |-> lower_q == 8'h00)
    else $error("lower limit reset wrong");
  a_abort_due: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    CC_ABORT_O |-> $past(CC_BUSY_I) && ($past(step_q) + 7'd1 >= $past(ctrl_link_timeout_count)))
    else $error("abort before timeout");
  a_tmo_rst: assert property (@(posedge CLOCK_I)
    $past(RST_I) && !RST_I |-> tmo_q[7:1] == 7'h7f && !tmo_q[0])
    else $error("timeout field reset wrong");
  a_off_quiet: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    $past(ctrl_link_timeout_off) |-> !CC_ABORT_O)
    else $error("abort while timeout off");
  a_remote_block: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    REG_WR_I && REG_REMOTE_I && wr_block |=> $stable(upper_q) && $stable(first_q) && REG_WREJ_O)
    else $error("blocked remote write landed");
  a_local_write: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    REG_WR_I && !REG_REMOTE_I && REG_ADDR_I == OFS_PAR_UPPER |=> upper_q == $past(REG_WDATA_I))
    else $error("local write lost");
  // a raised fault only drops on its own clear
  a_fault_hold: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    PARITY_FAULT_O[0] && !PAR_CLR_I[0] |=> PARITY_FAULT_O[0])
    else $error("parity fault dropped");
endmodule

// ==== hdl/cfg_regs_pkg.sv ====
package cfg_regs_pkg;
  // register offsets on the configuration port
  localparam logic [7:0] OFS_PAR_UPPER  = 8'h05;
  localparam logic [7:0] OFS_PAR_LOWER  = 8'h06;
  localparam logic [7:0] OFS_TMO_CTRL   = 8'h07;
  localparam logic [7:0] OFS_I2C_FIRST  = 8'h08;
  localparam logic [7:0] OFS_I2C_SECOND = 8'h09;
  // reset values
  localparam logic [7:0] RST_PAR_UPPER  = 8'h01;
  localparam logic [7:0] RST_PAR_LOWER  = 8'h00;
  localparam logic [7:0] RST_TMO_CTRL   = 8'hfe;
  localparam logic [7:0] RST_I2C_FIRST  = 8'h1c;
  localparam logic [7:0] RST_I2C_SECOND = 8'h10;
  // field positions
  localparam int TMO_CNT_LSB   = 1;
  localparam int TMO_OFF_BIT   = 0;
  localparam int WR_BLOCK_BIT  = 7;
  localparam int HOLD_LSB      = 4;
  localparam int FILT_LSB      = 0;
  localparam int SETUP_LSB     = 4;
  localparam int DELAY_LSB     = 2;
  localparam int WD_FAST_BIT   = 1;
  localparam int WD_OFF_BIT    = 0;
  // timing figures in their own units
  localparam int CLK_NS        = 20;
  localparam int TMO_STEP_MS   = 2;
  localparam int HOLD_STEP_NS  = 40;
  localparam int FILT_STEP_NS  = 5;
  localparam int SETUP_BASE_NS = 80;
  localparam int SETUP_STEP_NS = 640;
  localparam int DELAY_BASE_NS = 240;
  localparam int DELAY_STEP_NS = 40;
  localparam int WD_FAST_US    = 50;
  localparam int WD_SLOW_S     = 1;
  localparam int RECOV_HALF_NS = 5000;
  localparam int RECOV_PULSES  = 9;
  // derived cycle counts at 50 MHz
  localparam int TMO_STEP_CYC  = TMO_STEP_MS * 1000000 / CLK_NS;
  localparam int HOLD_STEP_CYC = (HOLD_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_BASE_CYC = (SETUP_BASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_STEP_CYC = (SETUP_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int DELAY_BASE_CYC = (DELAY_BASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int DELAY_STEP_CYC = (DELAY_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WD_FAST_CYC   = WD_FAST_US * 1000 / CLK_NS;
  localparam int WD_SLOW_CYC   = WD_SLOW_S * 1000000000 / CLK_NS;
  localparam int RECOV_HALF_CYC = RECOV_HALF_NS / CLK_NS;
  // watchdog states
  typedef enum logic [1:0] {WD_WATCH, WD_FREE, WD_RECOVER} wd_state_t;
endpackage

// ==== hdl/bus_watchdog.sv ====
`timescale 1ns/1ps
module bus_watchdog
  import cfg_regs_pkg::*;
#(
  parameter int SLOW_CYC = WD_SLOW_CYC,   // slow expiry count
  parameter int FAST_CYC = WD_FAST_CYC,   // fast expiry count
  parameter int HALF_CYC = RECOV_HALF_CYC // recovery half period
) (
  input  wire logic clk_i,     // system clock
  input  wire logic rst_i,     // sync reset, high
  input  wire logic en_i,      // watchdog running
  input  wire logic fast_i,    // short expiry select
  input  wire logic scl_i,     // filtered scl
  input  wire logic sda_i,     // filtered sda
  output logic      free_o,    // bus judged free
  output logic      recov_o,   // recovery in progress
  output logic      scl_oe_o   // pull scl low
);
  wd_state_t   state_q;        // watchdog state
  logic [25:0] timer_q;        // quiet-time counter
  logic [4:0]  edges_q;        // recovery half periods done
  logic        scl_p_q;        // previous scl
  logic        sda_p_q;        // previous sda
  // any line change counts as signalling
  wire activity = (scl_i != scl_p_q) || (sda_i != sda_p_q);
  wire [25:0] limit = fast_i ? 26'(FAST_CYC) : 26'(SLOW_CYC);
  wire expired = (timer_q >= limit - 26'd1);
  wire half_done = (timer_q >= 26'(HALF_CYC - 1));

  // line history for activity detection
  always_ff @(posedge clk_i) begin
    scl_p_q <= rst_i ? 1'b1 : scl_i;
    sda_p_q <= rst_i ? 1'b1 : sda_i;
  end

  // watch, free and recovery sequencing
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      state_q  <= WD_WATCH;
      timer_q  <= '0;
      edges_q  <= '0;
      free_o   <= 1'b0;
      recov_o  <= 1'b0;
      scl_oe_o <= 1'b0;
    end else begin
      case (state_q)
        WD_WATCH: begin
          timer_q <= (activity || expired) ? '0 : timer_q + 26'd1;
          if (!activity && expired && sda_i) begin
            state_q <= WD_FREE;
            free_o  <= 1'b1;
          end else if (!activity && expired) begin
            state_q <= WD_RECOVER;
            recov_o <= 1'b1;
            edges_q <= '0;
          end
        end
        WD_FREE: begin
          // leave as soon as anyone signals again
          if (activity) begin
            state_q <= WD_WATCH;
            free_o  <= 1'b0;
          end
        end
        default: begin
          // own scl toggling is not treated as activity here
          timer_q <= half_done ? '0 : timer_q + 26'd1;
          if (half_done) begin
            scl_oe_o <= ~scl_oe_o;
            edges_q  <= edges_q + 5'd1;
            if (edges_q == 5'(2 * RECOV_PULSES - 1)) begin
              state_q <= WD_WATCH;
              recov_o <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // recovery lasts at least eight cycles once started
  a_recover_len: assert property (@(posedge clk_i) disable iff (rst_i || !en_i)
    $rose(recov_o) |-> recov_o [*8])
    else $error("bus recovery ended too early");
endmodule

// ==== verification/i2c_bus_peer.sv ====
`timescale 1ns/1ps
// far-side model of the local bus: pull-ups on both lines, a target that
// can hold sda low, and a one-shot glitch source on sda
module i2c_bus_peer (
  input  wire logic scl_oe_i,    // device pulls scl
  input  wire logic scl_drv_i,   // device scl level when pulling
  input  wire logic sda_hold_i,  // target holds sda low
  input  wire logic glitch_i,    // short low spike on sda
  output logic      scl_o,       // resolved scl wire
  output logic      sda_o        // resolved sda wire
);
  // open drain: released lines float to the pull-up level, never x
  assign scl_o = scl_oe_i ? scl_drv_i : 1'b1;
  assign sda_o = ~(sda_hold_i | glitch_i);
endmodule

// ==== verification/test_link_ctrl_i2c_config_regs.sv ====
`timescale 1ns/1ps
module test_link_ctrl_i2c_config_regs
  import cfg_regs_pkg::*;
;
  localparam int STEP = 8;    // shortened 2 ms step
  localparam int SLOW = 300;  // shortened slow expiry
  logic       clk = 0, rst = 1, wr = 0, rd = 0, remote = 0, busy = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00;  // register port drive
  logic [1:0] perr = 2'h0, pclr = 2'h0;     // parity events
  logic       sda_low = 0, glitch = 0;      // bus peer controls
  logic [7:0] rdata;                        // read data
  logic [1:0] fault;                        // per-port fault flags
  logic [3:0] hold;                         // hold cycles
  logic [8:0] ack;                          // ack setup cycles
  logic [4:0] dly;                          // sda launch cycles
  logic       rvalid, wrej, abort, scl, sda, scl_drv, scl_oe, free, recover, sda_f, scl_f;
  int         fails = 0, n_checks = 0;
  // 50 mhz clock
  always #10 clk = ~clk;
  link_ctrl_cfg #(.NUM_PORTS(2), .STEP_CYC(STEP), .SLOW_CYC(SLOW)) DUT (
    .CLOCK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_REMOTE_I(remote), .REG_RDATA_O(rdata),
    .REG_RVALID_O(rvalid), .REG_WREJ_O(wrej), .PAR_ERR_I(perr), .PAR_CLR_I(pclr),
    .PARITY_FAULT_O(fault), .CC_BUSY_I(busy), .CC_ABORT_O(abort), .SCL_I(scl),
    .SDA_I(sda), .SCL_FILT_O(scl_f), .SDA_FILT_O(sda_f), .SDA_HOLD_CYC_O(hold),
    .ACK_SETUP_CYC_O(ack), .SDA_DELAY_CYC_O(dly), .SCL_O(scl_drv), .SCL_OE_O(scl_oe),
    .BUS_FREE_O(free), .BUS_RECOVER_O(recover));
  i2c_bus_peer peer (.scl_oe_i(scl_oe), .scl_drv_i(scl_drv), .sda_hold_i(sda_low),
    .glitch_i(glitch), .scl_o(scl), .sda_o(sda));
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // advance n cycles, land just after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one write, judge the refusal pulse
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic rem,
                        input logic rej);
    @(posedge clk); #1;
    addr = a; wdata = d; remote = rem; wr = 1;
    cyc(1);
    wr = 0; remote = 0;
    check(16'(wrej), 16'(rej));
  endtask
  // one read, judge valid and data
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk); #1;
    addr = a; rd = 1;
    cyc(1);
    rd = 0;
    check(16'(rvalid), 16'h1);
    check(16'(rdata), 16'(exp));
  endtask
  // one-cycle parity error / clear pulse
  task automatic pulse(input logic [1:0] e, input logic [1:0] c);
    @(posedge clk); #1;
    perr = e; pclr = c;
    cyc(1);
    perr = 2'h0; pclr = 2'h0;
  endtask
  // reset values and derived timing outputs
  task automatic t_reset();
    rd_chk(8'h05, 8'h01);
    rd_chk(8'h06, 8'h00);
    rd_chk(8'h07, 8'hfe);
    rd_chk(8'h08, 8'h1c);
    rd_chk(8'h09, 8'h10);
    rd_chk(8'h0a, 8'h00);
    check(16'(hold), 16'(HOLD_STEP_CYC));
    check(16'(ack), 16'(SETUP_BASE_CYC + SETUP_STEP_CYC));
    check(16'(dly), 16'(DELAY_BASE_CYC));
    check(16'(scl_drv), 16'h0);
  endtask
  // remote writes refused only while blocked; local ones always land
  task automatic t_remote();
    wr_reg(8'h08, 8'h9c, 1'b0, 1'b0);
    wr_reg(8'h05, 8'h55, 1'b1, 1'b1);
    rd_chk(8'h05, 8'h01);
    wr_reg(8'h05, 8'h00, 1'b0, 1'b0);
    rd_chk(8'h05, 8'h00);
    wr_reg(8'h08, 8'h1c, 1'b0, 1'b0);
    wr_reg(8'h06, 8'h02, 1'b1, 1'b0);
    rd_chk(8'h06, 8'h02);
  endtask
  // limit 0x0002: first error quiet, second raises port 0 only;
  // then port 1 reaches the limit in the cycle of its own clear
  task automatic t_parity();
    pulse(2'h1, 2'h0);
    cyc(2);
    check(16'(fault), 16'h0);
    pulse(2'h1, 2'h0);
    cyc(1);
    check(16'(fault), 16'h1);
    pulse(2'h0, 2'h1);
    cyc(1);
    check(16'(fault), 16'h0);
    pulse(2'h2, 2'h0);
    pulse(2'h2, 2'h2);
    cyc(1);
    check(16'(fault), 16'h2);
    pulse(2'h0, 2'h2);
    cyc(1);
    check(16'(fault), 16'h0);
  endtask
  // two steps until abort, then nothing while switched off
  task automatic t_timeout();
    int n;
    logic seen;
    n = 0;
    seen = 0;
    wr_reg(8'h07, 8'h04, 1'b0, 1'b0);
    busy = 1;
    while (abort !== 1'b1 && n < 60) begin
      cyc(1);
      n++;
    end
    busy = 0;
    check(16'(n >= 2 * STEP && n <= 2 * STEP + 1), 16'h1);
    wr_reg(8'h07, 8'h05, 1'b0, 1'b0);
    busy = 1;
    repeat (40) begin
      cyc(1);
      if (abort === 1'b1) seen = 1;
    end
    busy = 0;
    check(16'(seen), 16'h0);
  endtask
  // field positions feed the timing outputs
  task automatic t_cfg();
    wr_reg(8'h08, 8'h3c, 1'b0, 1'b0);
    wr_reg(8'h09, 8'h2c, 1'b0, 1'b0);
    cyc(2);
    check(16'(hold), 16'(3 * HOLD_STEP_CYC));
    check(16'(ack), 16'(SETUP_BASE_CYC + 2 * SETUP_STEP_CYC));
    check(16'(dly), 16'(DELAY_BASE_CYC + 3 * DELAY_STEP_CYC));
    rd_chk(8'h09, 8'h2c);
  endtask
  // free after a quiet high bus, nine pulses for a stuck one, silence when off
  task automatic t_watch();
    int n, pulses;
    logic prev, seen;
    sda_low = 1;
    cyc(20);
    sda_low = 0;
    n = 0;
    while (free !== 1'b1 && n < SLOW + 60) begin
      cyc(1);
      n++;
    end
    check(16'(n >= SLOW - 15 && n < SLOW + 60), 16'h1);
    glitch = 1;
    cyc(1);
    glitch = 0;
    seen = 0;
    repeat (10) begin
      if (sda_f !== 1'b1 || scl_f !== 1'b1 || free !== 1'b1) seen = 1;
      cyc(1);
    end
    check(16'(seen), 16'h0);
    sda_low = 1;
    n = 0;
    while (recover !== 1'b1 && n < SLOW + 60) begin
      cyc(1);
      n++;
    end
    check(16'(n >= SLOW - 15 && n < SLOW + 60), 16'h1);
    pulses = 0;
    prev = scl_oe;
    n = 0;
    while (recover === 1'b1 && n < 6000) begin
      cyc(1);
      n++;
      if (scl_oe === 1'b1 && prev !== 1'b1) pulses++;
      prev = scl_oe;
    end
    check(16'(pulses), 16'(RECOV_PULSES));
    wr_reg(8'h09, 8'h2d, 1'b0, 1'b0);
    seen = 0;
    repeat (SLOW + 60) begin
      cyc(1);
      if (recover === 1'b1) seen = 1;
    end
    check(16'(seen), 16'h0);
    sda_low = 0;
    cyc(10);
    // fast expiry, unshortened, from the moment the watchdog is re-enabled
    wr_reg(8'h09, 8'h12, 1'b0, 1'b0);
    n = 0;
    while (free !== 1'b1 && n < WD_FAST_CYC + 60) begin
      cyc(1);
      n++;
    end
    check(16'(n >= WD_FAST_CYC - 10 && n <= WD_FAST_CYC + 20), 16'h1);
  endtask
  // verdict, single exit
  task automatic end_of_test();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst = 0;
    t_reset();
    t_remote();
    t_parity();
    t_timeout();
    t_cfg();
    t_watch();
    end_of_test();
  end
  // hang guard, about two and a half times the expected run
  initial begin
    #400000;
    fails++;
    end_of_test();
  end
endmodule
